// file: rtl/gpopwm_pkg.sv
// Constants for the pin output level and pin 0 PWM block.
// Assumes one 200 MHz clock and an APB slave port with 32-bit data.
package gpopwm_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_STATUS = 10'h04C;
    localparam logic [9:0] IDX_PIN_CFG = 10'h04D;
    localparam logic [9:0] IDX_LEVELS = 10'h04E;
    localparam logic [9:0] IDX_PWM0 = 10'h04F;
    // Width of every register
    localparam int unsigned REG_W = 16;
    localparam int unsigned PIN_N = 5;
    // Reset values
    localparam logic [15:0] RST_LEVELS = 16'h0000;
    localparam logic [15:0] RST_PWM0 = 16'h007F;
    localparam logic [15:0] RST_PIN_CFG = 16'h0000;
    // Writable bits of the pin config register; bit 1 reads zero
    localparam logic [15:0] PIN_CFG_WMASK = 16'h07FD;
    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned SRC_LSB = 0;
    localparam int unsigned DIR_LSB = 5;
    localparam int unsigned FMT0_BIT = 10;
    localparam int unsigned TB_LSB = 14;
    localparam int unsigned HC_LSB = 7;
    localparam int unsigned LC_LSB = 0;
    localparam int unsigned CNT_W = 7;
    localparam int unsigned TB_SEL_W = 2;
    // Time base lengths in master clock periods
    localparam int unsigned TB_LEN_0 = 16;
    localparam int unsigned TB_LEN_1 = 64;
    localparam int unsigned TB_LEN_2 = 256;
    localparam int unsigned TB_LEN_3 = 1024;
    localparam int unsigned PRE_W = 10;
endpackage : gpopwm_pkg

// file: rtl/gpopwm_pin_drv.sv
// One pin output stage: direction, source select and registered level.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module gpopwm_pin_drv #(
    parameter bit HAS_ALT = 1'b1  // Pin has an alternate output source
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic dirOut,
    input wire logic srcData,
    input wire logic dataLevel,
    input wire logic altLevel,
    output logic pinLevel,
    output logic pinOe
);
    logic levelD;  // Next pin level
    logic levelQ;  // Registered pin level
    logic oeD;  // Next enable
    logic oeQ;  // Registered enable

    ////////////////////////////////////////////////////////////////////////////
    // Choose what drives the pin
    always_comb begin
        oeD = dirOut;
        levelD = 1'b0;
        if (dirOut) begin
            // source bit routes data or alternate
            if (!HAS_ALT || srcData) begin
                levelD = dataLevel;
            end else begin
                // Data bit ignored while alternate drives the pin
                levelD = altLevel;
            end
        end
    end

    // Registered so the pin never glitches on a mux change
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            levelQ <= 1'b0;
            oeQ <= 1'b0;
        end else begin
            levelQ <= levelD;
            oeQ <= oeD;
        end
    end

    assign pinLevel = levelQ;
    assign pinOe = oeQ;
endmodule : gpopwm_pin_drv
`default_nettype wire

// file: rtl/gpopwm_pwm_gen.sv
// PWM generator for the logic-low level of pin 0.
// Assumes clk is the master clock that sets the time base.
`timescale 1ns/100ps
`default_nettype none
module gpopwm_pwm_gen #(
    parameter int unsigned CW = gpopwm_pkg::CNT_W  // Counter field width
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [gpopwm_pkg::TB_SEL_W-1:0] tbSel,
    input wire logic [CW-1:0] highCnt,
    input wire logic [CW-1:0] lowCnt,
    output logic pwmLevel
);
    typedef enum logic {GPOPWM_HIGH, GPOPWM_LOW} gpopwm_phase_t;

    gpopwm_phase_t phaseD, phaseQ;  // Current half of the period
    logic [gpopwm_pkg::PRE_W-1:0] preD, preQ;  // Clocks within one time base
    logic [gpopwm_pkg::PRE_W-1:0] tbLast;  // Last prescaler value
    logic [CW-1:0] cntD, cntQ;  // Time bases within the phase
    logic outD, outQ;  // Registered waveform
    logic tick;  // One time base elapsed

    // Refuse counter widths that the phase counter cannot serve
    if (CW < 1 || CW > 16) begin : g_bad_cw
        $error("gpopwm_pwm_gen: bad counter width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and phase sequencer
    always_comb begin
        // time base chosen by the select code
        unique case (tbSel)
            2'h0: tbLast = gpopwm_pkg::PRE_W'(gpopwm_pkg::TB_LEN_0 - 1);
            2'h1: tbLast = gpopwm_pkg::PRE_W'(gpopwm_pkg::TB_LEN_1 - 1);
            2'h2: tbLast = gpopwm_pkg::PRE_W'(gpopwm_pkg::TB_LEN_2 - 1);
            2'h3: tbLast = gpopwm_pkg::PRE_W'(gpopwm_pkg::TB_LEN_3 - 1);
        endcase
        // A shorter select mid-count wraps at once instead of running on
        tick = (preQ >= tbLast);
        preD = tick ? '0 : preQ + 1'b1;
        phaseD = phaseQ;
        cntD = cntQ;
        // high for highCnt bases, then low for lowCnt bases
        if (tick) begin
            cntD = cntQ + 1'b1;
            unique case (phaseQ)
                GPOPWM_HIGH: begin
                    if (cntD >= highCnt) begin
                        phaseD = GPOPWM_LOW;
                        cntD = '0;
                    end
                end
                GPOPWM_LOW: begin
                    if (cntD >= lowCnt) begin
                        phaseD = GPOPWM_HIGH;
                        cntD = '0;
                    end
                end
            endcase
        end
        // Zero high count gives static low, zero low count static high
        if (highCnt == '0) begin
            outD = 1'b0;
        end else if (lowCnt == '0) begin
            outD = 1'b1;
        end else begin
            outD = (phaseQ == GPOPWM_HIGH);
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            preQ <= '0;
            cntQ <= '0;
            phaseQ <= GPOPWM_HIGH;
            outQ <= 1'b0;
        end else begin
            preQ <= preD;
            cntQ <= cntD;
            phaseQ <= phaseD;
            outQ <= outD;
        end
    end

    assign pwmLevel = outQ;
endmodule : gpopwm_pwm_gen
`default_nettype wire

// file: rtl/gpopwm_top.sv
// Pin output level and pin 0 PWM register block with an APB slave port.
// Assumes alternate pin sources come from logic on the same clock.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module gpopwm_top #(
    parameter int unsigned ADDR_W = 12  // APB byte address width
) (
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Alternate pin sources
    input wire logic missing_host_detect_out,
    input wire logic fault_ind_out,
    input wire logic overcurrent_cmp_a_out,
    input wire logic overcurrent_cmp_b_out,
    // Pins
    output logic [gpopwm_pkg::PIN_N-1:0] pinOut,
    output logic [gpopwm_pkg::PIN_N-1:0] pinOe
);
    localparam int unsigned RW = gpopwm_pkg::REG_W;
    localparam int unsigned NP = gpopwm_pkg::PIN_N;
    localparam int unsigned CW = gpopwm_pkg::CNT_W;

    // Decode reads paddr[11:2], so a narrower bus cannot reach the map
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("gpopwm_top: ADDR_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [RW-1:0] pin_output_levels_d, pin_output_levels_q;  // Level register
    logic [RW-1:0] pin0_low_level_pwm_config_d, pin0_low_level_pwm_config_q;
    logic [RW-1:0] pinCfgD, pinCfgQ;  // Direction, source, format bits
    logic [31:0] rdataD, rdataQ;  // Read data, captured in setup phase
    logic errD, errQ;  // Error answer, captured in setup phase
    logic [9:0] regIdx;  // Word index of the access
    logic aligned;  // Low address bits are zero
    logic hitStatus, hitCfg, hitLevels, hitPwm0;  // Decode hits
    logic mapped;  // Any register hit
    logic setup;  // APB setup cycle
    logic wrAccess;  // Access phase of a write
    logic [RW-1:0] laneMask;  // Byte lanes enabled by pstrb
    logic [RW-1:0] wrData;  // Write data of the low half word
    logic [NP-1:0] altLevel;  // Alternate function per pin
    logic [NP-1:0] dataLevel;  // Data path level per pin
    logic [NP-1:0] hasAltBits;  // Which pins own an alternate source
    logic [NP-1:0] srcBits;  // Source select per pin
    logic [NP-1:0] dirBits;  // Direction per pin
    logic pwmLevel;  // Pin 0 logic-low waveform
    logic [RW-1:0] statusWord;  // Read-only live pin state

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb begin
        regIdx = paddr[11:2];
        aligned = (paddr[1:0] == 2'h0);
        // Upper address bits must be zero for a hit
        if (ADDR_W > 12) begin
            aligned = aligned && ((paddr >> 12) == '0);
        end
        hitStatus = aligned && (regIdx == gpopwm_pkg::IDX_STATUS);
        hitCfg = aligned && (regIdx == gpopwm_pkg::IDX_PIN_CFG);
        hitLevels = aligned && (regIdx == gpopwm_pkg::IDX_LEVELS);
        hitPwm0 = aligned && (regIdx == gpopwm_pkg::IDX_PWM0);
        mapped = hitStatus || hitCfg || hitLevels || hitPwm0;
        setup = psel && !penable;
        wrAccess = psel && penable && pwrite;
        laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        wrData = pwdata[RW-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file next values
    always_comb begin
        pin_output_levels_d = pin_output_levels_q;
        pin0_low_level_pwm_config_d = pin0_low_level_pwm_config_q;
        pinCfgD = pinCfgQ;
        if (wrAccess && hitLevels) begin
            // spare bits stored, read back, drive nothing
            pin_output_levels_d = (pin_output_levels_q & ~laneMask)
                                | (wrData & laneMask);
        end
        if (wrAccess && hitPwm0) begin
            // base select, high and low counts
            pin0_low_level_pwm_config_d = (pin0_low_level_pwm_config_q & ~laneMask)
                                        | (wrData & laneMask);
        end
        if (wrAccess && hitCfg) begin
            // Reserved bit 1 and upper bits stay zero
            pinCfgD = ((pinCfgQ & ~laneMask) | (wrData & laneMask))
                    & gpopwm_pkg::PIN_CFG_WMASK;
        end
    end

    // Register file flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_output_levels_q <= gpopwm_pkg::RST_LEVELS;
            pin0_low_level_pwm_config_q <= gpopwm_pkg::RST_PWM0;
            pinCfgQ <= gpopwm_pkg::RST_PIN_CFG;
        end else begin
            pin_output_levels_q <= pin_output_levels_d;
            pin0_low_level_pwm_config_q <= pin0_low_level_pwm_config_d;
            pinCfgQ <= pinCfgD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and error, prepared in the setup cycle
    always_comb begin
        statusWord = '0;
        statusWord[NP-1:0] = pinOut;
        statusWord[2*NP-1:NP] = pinOe;
        statusWord[2*NP] = pwmLevel;
        rdataD = rdataQ;
        errD = errQ;
        // Setup cycle latches the answer so prdata comes from a flop
        if (setup) begin
            rdataD = '0;
            errD = !mapped;
            if (hitStatus) begin
                rdataD[RW-1:0] = statusWord;
            end else if (hitCfg) begin
                rdataD[RW-1:0] = pinCfgQ;
            end else if (hitLevels) begin
                rdataD[RW-1:0] = pin_output_levels_q;
            end else if (hitPwm0) begin
                rdataD[RW-1:0] = pin0_low_level_pwm_config_q;
            end
        end
    end

    // Answer flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdataQ <= '0;
            errQ <= 1'b0;
        end else begin
            rdataQ <= rdataD;
            errQ <= errD;
        end
    end

    // Zero-wait slave: every access phase finishes in one cycle
    assign pready = 1'b1;
    assign prdata = rdataQ;
    // Error only shows during the access phase
    assign pslverr = errQ && psel && penable;

    ////////////////////////////////////////////////////////////////////////////
    // Pin 0 low-level PWM generator
    gpopwm_pwm_gen #(
        .CW(CW)
    ) u_pwm0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .tbSel(pin0_low_level_pwm_config_q[gpopwm_pkg::TB_LSB +: gpopwm_pkg::TB_SEL_W]),
        .highCnt(pin0_low_level_pwm_config_q[gpopwm_pkg::HC_LSB +: CW]),
        .lowCnt(pin0_low_level_pwm_config_q[gpopwm_pkg::LC_LSB +: CW]),
        .pwmLevel(pwmLevel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin data and alternate sources
    always_comb begin
        dirBits = pinCfgQ[gpopwm_pkg::DIR_LSB +: NP];
        srcBits = pinCfgQ[gpopwm_pkg::SRC_LSB +: NP];
        // bits 4:0 give the static pin levels
        dataLevel = pin_output_levels_q[NP-1:0];
        // Pin 0 in PWM format encodes a low level as the waveform;
        // high level stays static since its PWM setting is elsewhere
        if (pinCfgQ[gpopwm_pkg::FMT0_BIT] && !pin_output_levels_q[0]) begin
            dataLevel[0] = pwmLevel;
        end
        // pin 0 alternate is missing-host detect
        altLevel[0] = missing_host_detect_out;
        // pin 1 has no alternate source
        altLevel[1] = 1'b0;
        // pin 2 alternate is the fault output
        altLevel[2] = fault_ind_out;
        // pin 3 alternate is comparator A
        altLevel[3] = overcurrent_cmp_a_out;
        // pin 4 alternate is comparator B
        altLevel[4] = overcurrent_cmp_b_out;
        hasAltBits = 5'h1D;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin output stages
    // level reaches the pin one edge after the write
    for (genvar p = 0; p < NP; p++) begin : g_pin
        gpopwm_pin_drv #(
            .HAS_ALT(p != 1)
        ) u_pin (
            .clk(clk),
            .sys_rst(sys_rst),
            .dirOut(dirBits[p]),
            .srcData(srcBits[p] || !hasAltBits[p]),
            .dataLevel(dataLevel[p]),
            .altLevel(altLevel[p]),
            .pinLevel(pinOut[p]),
            .pinOe(pinOe[p])
        );
    end
endmodule : gpopwm_top
`default_nettype wire

// file: test/gpopwm_pad_load.sv
// Far-side model: the circuitry hanging on the five pins.
// Assumes pinOut and pinOe come straight from the block, same clock.
`timescale 1ns/100ps
`default_nettype none
module gpopwm_pad_load (
    input wire logic [4:0] pinOut,
    input wire logic [4:0] pinOe,
    output logic [4:0] padLevel
);
    // Weak pull-down on every pad: an undriven pin reads low, never its last level
    assign padLevel = pinOut & pinOe;
endmodule : gpopwm_pad_load
`default_nettype wire

// file: test/gpopwm_top_sva.sv
// Checker for the pin output block, bound to the top module's ports.
// Assumes paddr holds byte addresses and pready is sampled with the access.
`timescale 1ns/100ps
`default_nettype none
module gpopwm_top_sva #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic missing_host_detect_out,
    input wire logic fault_ind_out,
    input wire logic overcurrent_cmp_a_out,
    input wire logic overcurrent_cmp_b_out,
    input wire logic [4:0] pinOut,
    input wire logic [4:0] pinOe
);
    localparam logic [ADDR_W-1:0] A_CFG = 'h134; // Pin config word
    localparam logic [ADDR_W-1:0] A_LVL = 'h138; // Output level word
    logic wrAcc; // Write access phase
    logic [15:0] bMask; // Byte lanes enabled
    logic [15:0] cfgS_d, cfgS_q, lvlS_d, lvlS_q; // Shadow registers
    logic [4:0] srcSel, altVec, pinExp; // Expected pin levels
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    assign wrAcc = psel & penable & pwrite;
    assign bMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    // Pin 1 has no alternate source, so it always follows its data bit
    assign srcSel = {cfgS_q[4:2], 1'b1, cfgS_q[0]};
    assign altVec = {overcurrent_cmp_b_out, overcurrent_cmp_a_out, fault_ind_out, 1'b0,
                     missing_host_detect_out};
    assign pinExp = ((srcSel & lvlS_q[4:0]) | (~srcSel & altVec)) & cfgS_q[9:5];
    ////////////////////////////////////////////////////////////////////////////
    // Shadow next values from observed writes
    always_comb begin
        cfgS_d = cfgS_q;
        lvlS_d = lvlS_q;
        if (wrAcc && paddr == A_CFG) begin
            cfgS_d = (cfgS_q & ~(bMask & gpopwm_pkg::PIN_CFG_WMASK))
                   | (pwdata[15:0] & bMask & gpopwm_pkg::PIN_CFG_WMASK);
        end
        if (wrAcc && paddr == A_LVL) begin
            lvlS_d = (lvlS_q & ~bMask) | (pwdata[15:0] & bMask);
        end
    end
    // Shadow registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfgS_q <= 16'h0000;
            lvlS_q <= 16'h0000;
        end else begin
            cfgS_q <= cfgS_d;
            lvlS_q <= lvlS_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    AST_RST_QUIET: assert property (
        $past(sys_rst) |-> pinOe == 5'h00 && pinOut == 5'h00) else $error("Pins live after reset");
    AST_OE_DIR: assert property (
        !$past(sys_rst) |-> pinOe == $past(cfgS_q[9:5])) else $error("Enable differs from direction");
    AST_PIN0: assert property (
        !$past(sys_rst) && !$past(cfgS_q[10]) |-> pinOut[0] == $past(pinExp[0]))
        else $error("Pin 0 level wrong");
    AST_PIN1: assert property (
        !$past(sys_rst) |-> pinOut[1] == $past(pinExp[1])) else $error("Pin 1 level wrong");
    AST_PIN2: assert property (
        !$past(sys_rst) |-> pinOut[2] == $past(pinExp[2])) else $error("Pin 2 level wrong");
    AST_PIN3: assert property (
        !$past(sys_rst) |-> pinOut[3] == $past(pinExp[3])) else $error("Pin 3 level wrong");
    AST_PIN4: assert property (
        !$past(sys_rst) |-> pinOut[4] == $past(pinExp[4])) else $error("Pin 4 level wrong");
    AST_RD_LVL: assert property (
        psel && penable && !pwrite && paddr == A_LVL |-> prdata == {16'h0000, lvlS_q})
        else $error("Level readback wrong");
    AST_RD_CFG: assert property (
        psel && penable && !pwrite && paddr == A_CFG |-> prdata == {16'h0000, cfgS_q})
        else $error("Pin config readback wrong");
    AST_READY: assert property (
        psel && penable |-> pready) else $error("Access phase not answered");
    COV_PWM_RUN: cover property (cfgS_q[10] && pinOe[0] && $rose(pinOut[0]));
    COV_LVL_WR: cover property (wrAcc && paddr == A_LVL);
    COV_ALT_PIN: cover property (pinOe[0] && !cfgS_q[0] && pinOut[0]);
    COV_ERR: cover property (pslverr);
endmodule : gpopwm_top_sva
bind gpopwm_top gpopwm_top_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .missing_host_detect_out(missing_host_detect_out), .fault_ind_out(fault_ind_out),
    .overcurrent_cmp_a_out(overcurrent_cmp_a_out), .overcurrent_cmp_b_out(overcurrent_cmp_b_out),
    .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire

// file: test/gpio_output_data_and_pwm_level_cfg_tb.sv
// Self-checking bench: APB master, random pin set-ups, PWM timing.
// Assumes the pad load model and the bound checker sit beside the block.
`timescale 1ns/100ps
`default_nettype none
module gpio_output_data_and_pwm_level_cfg_tb;
    localparam logic [11:0] A_CFG = 12'h134, A_LVL = 12'h138, A_PWM = 12'h13C, A_BAD = 12'h200;
    localparam logic [11:0] A_STS = 12'h130; // Live pin state word
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000; // Byte address
    logic [31:0] pwdata = 32'h00000000, prdata, rd; // Bus data, last read
    logic [3:0] pstrb = 4'h0, altIn = 4'h0; // Strobes, alternate sources
    logic pready, pslverr, rdErr; // Bus answer
    logic [4:0] pinOut, pinOe, padLevel; // Pin side
    int error_cnt = 0, check_count = 0;
    always #2.5 clk = ~clk;
    gpopwm_top #(.ADDR_W(12)) u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .missing_host_detect_out(altIn[0]), .fault_ind_out(altIn[1]),
        .overcurrent_cmp_a_out(altIn[2]), .overcurrent_cmp_b_out(altIn[3]),
        .pinOut(pinOut), .pinOe(pinOe));
    gpopwm_pad_load u_load (.pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; entered and left on a rising edge, one idle cycle after
    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        @(posedge clk);
    endtask : apb
    // Cycles that pad 0 stays at one level; a stuck pad ends the run
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (padLevel[0] === lvl && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : run_len
    // Expected {enables, pad levels} from config, data and alternates
    function automatic logic [31:0] exp_pins(input logic [15:0] c, input logic [4:0] d,
                                             input logic [3:0] a);
        logic [4:0] src, lv;
        src = {c[4:2], 1'b1, c[0]};
        lv = (src & d) | (~src & {a[3:1], 1'b0, a[0]});
        return {22'h0, c[9:5], lv & c[9:5]};
    endfunction : exp_pins
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] c, d;
        int hi, lo;
        void'($urandom(96304));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, A_LVL, 16'h0000, 4'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, A_PWM, 16'h0000, 4'h0);
        chk(rd, 32'h0000007F);
        // Only byte lane 1 written, lane 0 keeps its reset value
        apb(1'b1, A_PWM, 16'hFFFF, 4'h2);
        apb(1'b0, A_PWM, 16'h0000, 4'h0);
        chk(rd, 32'h0000FF7F);
        apb(1'b0, A_BAD, 16'h0000, 4'h0);
        chk({31'h0, rdErr}, 32'h00000001);
        chk(rd, 32'h00000000);
        // Random direction, source, data and alternate levels
        repeat (24) begin
            c = 16'($urandom);
            d = 16'($urandom);
            c[10] = 1'b0;
            altIn <= 4'($urandom);
            apb(1'b1, A_CFG, c, 4'h3);
            apb(1'b1, A_LVL, d, 4'h3);
            @(posedge clk);
            chk({22'h0, pinOe, padLevel}, exp_pins(c, d[4:0], altIn));
            apb(1'b0, A_LVL, 16'h0000, 4'h0);
            chk(rd, {16'h0000, d});
            apb(1'b0, A_CFG, 16'h0000, 4'h0);
            chk(rd, {16'h0000, c & gpopwm_pkg::PIN_CFG_WMASK});
            apb(1'b0, A_STS, 16'h0000, 4'h0);
            chk(rd & 32'h000003FF, exp_pins(c, d[4:0], altIn));
        end
        // Pin 0 output, data source, PWM format, low level selected
        apb(1'b1, A_CFG, 16'h0421, 4'h3);
        apb(1'b1, A_LVL, 16'h0000, 4'h3);
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, A_PWM, {2'(t), 7'h02, 7'h01}, 4'h3);
            run_len(1'b1, hi);
            run_len(1'b0, lo);
            run_len(1'b1, hi);
            run_len(1'b0, lo);
            chk(32'(hi), 32'(2 * (16 << (2 * t))));
            chk(32'(lo), 32'(16 << (2 * t)));
        end
        // Zero high count static low, zero low count static high, level one static high
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, A_PWM, (k == 1) ? 16'h0180 : 16'h0005, 4'h3);
            apb(1'b1, A_LVL, (k == 2) ? 16'h0001 : 16'h0000, 4'h3);
            repeat (4) @(posedge clk);
            repeat (32) begin
                @(posedge clk);
                chk({31'h0, padLevel[0]}, (k != 0) ? 32'h00000001 : 32'h00000000);
            end
        end
        // Mid-run reset: registers and pins go back to their reset state
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk({22'h0, pinOe, padLevel}, 32'h00000000);
        apb(1'b0, A_LVL, 16'h0000, 4'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, A_PWM, 16'h0000, 4'h0);
        chk(rd, 32'h0000007F);
        apb(1'b0, A_CFG, 16'h0000, 4'h0);
        chk(rd, 32'h00000000);
        report_and_stop();
    end
endmodule : gpio_output_data_and_pwm_level_cfg_tb
`default_nettype wire
